// File: rtl/deac_device.sv
// Summary of operation
// - read byte ready next cycle after trigger
// - data byte holds until read, write or warm reset
// - firmware loads index and data first
// - 55h, AAh, then launch starts write
// - exact cycle spacing across unlock sequence
// - firmware keeps interrupts off during unlock
// - launch refused unless permit already set
// - hardware never clears the permit bit
// - clearing permit leaves running write intact
// - completion clears launch, sets done flag
// - firmware clears done flag, bit 7
// - firmware keeps permit clear when idle
// - power-up clears permit, settle blocks writes
// - readout lock never restricts cpu access
// - key port has no storage
// - firmware may verify write by readback
// - trigger bits set-only, hardware clears them
// - warm reset mid-write flags abort, clears
// - only low seven index bits decoded
// - each write erases location before programming
`timescale 1ns/1ps
`include "deac_defines.svh"
module deac_device #(
    parameter int unsigned SETTLE_CYCLES = `DEAC_SETTLE_CYCLES,
    parameter int unsigned PROG_CYCLES = `DEAC_PROG_CYCLES
) (
    input wire logic sys_clk,
    input wire logic nrst,
    deac_if.dev bus,
    input wire logic data_readout_lock,
    input wire logic [6:0] ext_addr,
    output logic [7:0] ext_data,
    output logic prog_busy
);
    import deac_pkg::*;

    // ****************************************************************
    // storage and state
    // ****************************************************************
    logic [7:0] mem [0:127];
    logic [7:0] data_r;
    logic [6:0] index_r;
    logic permit_r;
    logic abort_r;
    logic launch_r;
    logic read_r;
    logic done_r;
    logic [23:0] settle_cnt_r;
    logic settle_done_r;
    deac_unlock_t ulk_r;
    logic [1:0] gap_cnt_r;
    logic [15:0] prog_cnt_r;
    logic [6:0] prog_index_r;
    logic [7:0] prog_data_r;
    logic [7:0] rdata_r;
    logic [1:0] lock_sync_r;
    logic [6:0] ext_addr_m_r;
    logic [6:0] ext_addr_s_r;
    logic [7:0] ext_data_r;

    logic warm;
    logic wr_pir;
    logic wr_data;
    logic wr_index;
    logic wr_ctrl;
    logic wr_key;
    logic unlock_ok;
    logic launch_ok;
    logic read_ok;
    logic prog_last;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
        return a == reg_addr;
    endfunction

    // ****************************************************************
    // decode
    // ****************************************************************
    assign warm = bus.warm_rst;
    assign wr_pir = bus.sfr_we && hit(bus.sfr_addr, `DEAC_PIR_ADDR);
    assign wr_data = bus.sfr_we && hit(bus.sfr_addr, `DEAC_DATA_ADDR);
    assign wr_index = bus.sfr_we && hit(bus.sfr_addr, `DEAC_INDEX_ADDR);
    assign wr_ctrl = bus.sfr_we && hit(bus.sfr_addr, `DEAC_CTRL_ADDR);
    assign wr_key = bus.sfr_we && hit(bus.sfr_addr, `DEAC_KEY_ADDR);
    assign prog_last = launch_r && (prog_cnt_r == 16'(PROG_CYCLES - 1));
    assign unlock_ok = (ulk_r == DEAC_ULK_KEY2) && (gap_cnt_r == 2'(`DEAC_KEY_GAP - 1));
    // a busy array refuses a second launch
    assign launch_ok = wr_ctrl && bus.sfr_wdata[`DEAC_LAUNCH_BIT] && unlock_ok && permit_r
                       && settle_done_r && !launch_r && !warm;
    assign read_ok = wr_ctrl && bus.sfr_wdata[`DEAC_READ_BIT] && !launch_r && !warm;

    // ****************************************************************
    // supply settle delay after power-up
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            settle_cnt_r <= 24'h00_0000;
            settle_done_r <= 1'b0;
        end else if (!settle_done_r) begin
            if (settle_cnt_r == 24'(SETTLE_CYCLES - 1)) begin
                settle_done_r <= 1'b1;
            end else begin
                settle_cnt_r <= settle_cnt_r + 24'h00_0001;
            end
        end
    end

    // ****************************************************************
    // unlock sequence detector
    // ****************************************************************
    // key writes are not stored anywhere; they only advance this tracker
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ulk_r <= DEAC_ULK_IDLE;
            gap_cnt_r <= 2'h0;
        end else if (warm) begin
            ulk_r <= DEAC_ULK_IDLE;
            gap_cnt_r <= 2'h0;
        end else if (wr_key) begin
            gap_cnt_r <= 2'h0;
            if (bus.sfr_wdata == `DEAC_KEY_FIRST) begin
                ulk_r <= DEAC_ULK_KEY1;
            end else if (bus.sfr_wdata == `DEAC_KEY_SECOND && ulk_r == DEAC_ULK_KEY1
                         && gap_cnt_r == 2'(`DEAC_KEY_GAP - 1)) begin
                ulk_r <= DEAC_ULK_KEY2;
            end else begin
                ulk_r <= DEAC_ULK_IDLE;
            end
        end else if (bus.sfr_we) begin
            // any other write, the launch itself included, spends the sequence
            ulk_r <= DEAC_ULK_IDLE;
        end else if (gap_cnt_r != 2'h3) begin
            gap_cnt_r <= gap_cnt_r + 2'h1;
        end
    end

    // ****************************************************************
    // control bits
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            permit_r <= 1'b0;
        end else if (wr_ctrl) begin
            permit_r <= bus.sfr_wdata[`DEAC_PERMIT_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            abort_r <= 1'b0;
        end else if (warm && launch_r) begin
            abort_r <= 1'b1;
        end else if (wr_ctrl) begin
            abort_r <= bus.sfr_wdata[`DEAC_ABORT_BIT];
        end
    end

    // writing zero to a trigger bit has no effect
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            read_r <= 1'b0;
        end else begin
            read_r <= read_ok;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            launch_r <= 1'b0;
        end else if (warm || prog_last) begin
            launch_r <= 1'b0;
        end else if (launch_ok) begin
            launch_r <= 1'b1;
        end
    end

    // ****************************************************************
    // self-timed write
    // ****************************************************************
    // index and data are latched at launch so firmware may touch them meanwhile
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prog_cnt_r <= 16'h0000;
            prog_index_r <= 7'h00;
            prog_data_r <= `DEAC_RESET_BYTE;
        end else if (launch_ok) begin
            prog_cnt_r <= 16'h0000;
            prog_index_r <= index_r;
            prog_data_r <= data_r;
        end else if (launch_r) begin
            prog_cnt_r <= prog_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (launch_r && !warm) begin
            if (prog_cnt_r == 16'h0000) begin
                mem[prog_index_r] <= `DEAC_ERASED;
            end
            if (prog_last) begin
                mem[prog_index_r] <= prog_data_r;
            end
        end
    end

    // set wins over a firmware clear in the same cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            done_r <= 1'b0;
        end else if (prog_last) begin
            done_r <= 1'b1;
        end else if (warm) begin
            done_r <= 1'b0;
        end else if (wr_pir) begin
            done_r <= bus.sfr_wdata[`DEAC_DONE_BIT];
        end
    end

    // ****************************************************************
    // data and index registers
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            data_r <= `DEAC_RESET_BYTE;
        end else if (warm) begin
            data_r <= `DEAC_RESET_BYTE;
        end else if (read_ok) begin
            data_r <= mem[index_r];
        end else if (wr_data) begin
            data_r <= bus.sfr_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            index_r <= 7'h00;
        end else if (warm) begin
            index_r <= 7'h00;
        end else if (wr_index) begin
            index_r <= bus.sfr_wdata[6:0];
        end
    end

    // ****************************************************************
    // read back
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= 8'h00;
        end else if (bus.sfr_re) begin
            case (bus.sfr_addr)
                `DEAC_PIR_ADDR: rdata_r <= {done_r, 7'h00};
                `DEAC_DATA_ADDR: rdata_r <= data_r;
                `DEAC_INDEX_ADDR: rdata_r <= {1'b0, index_r};
                `DEAC_CTRL_ADDR: rdata_r <= {4'h0, abort_r, permit_r, launch_r, read_r};
                default: rdata_r <= 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // external readout port
    // ****************************************************************
    // address is expected quasi-static, so a per-bit synchroniser is enough
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            lock_sync_r <= 2'b11;
            ext_addr_m_r <= 7'h00;
            ext_addr_s_r <= 7'h00;
        end else begin
            lock_sync_r <= {lock_sync_r[0], data_readout_lock};
            ext_addr_m_r <= ext_addr;
            ext_addr_s_r <= ext_addr_m_r;
        end
    end

    // the lock only hides the array from this port, never from the cpu
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ext_data_r <= 8'h00;
        end else begin
            ext_data_r <= lock_sync_r[1] ? mem[ext_addr_s_r] : 8'h00;
        end
    end

    assign bus.sfr_rdata = rdata_r;
    assign ext_data = ext_data_r;
    assign prog_busy = launch_r;
endmodule

// File: rtl/deac_defines.svh
`ifndef DEAC_DEFINES_SVH
`define DEAC_DEFINES_SVH
// ****************************************************************
// special function register addresses
// ****************************************************************
`define DEAC_PIR_ADDR 8'h0C
`define DEAC_DATA_ADDR 8'h9A
`define DEAC_INDEX_ADDR 8'h9B
`define DEAC_CTRL_ADDR 8'h9C
`define DEAC_KEY_ADDR 8'h9D
// ****************************************************************
// bit positions and values
// ****************************************************************
`define DEAC_DONE_BIT 7
`define DEAC_ABORT_BIT 3
`define DEAC_PERMIT_BIT 2
`define DEAC_LAUNCH_BIT 1
`define DEAC_READ_BIT 0
`define DEAC_KEY_FIRST 8'h55
`define DEAC_KEY_SECOND 8'hAA
`define DEAC_ERASED 8'hFF
`define DEAC_RESET_BYTE 8'h00
`define DEAC_CTRL_PERMIT 8'h04
`define DEAC_CTRL_GO 8'h06
`define DEAC_CTRL_READ 8'h01
// ****************************************************************
// timing
// ****************************************************************
`define DEAC_KEY_GAP 2
`define DEAC_CLK_MHZ 200
`define DEAC_SETTLE_MS 72
`define DEAC_SETTLE_CYCLES (`DEAC_SETTLE_MS * 1000 * `DEAC_CLK_MHZ)
`define DEAC_PROG_CYCLES 1000
// ****************************************************************
// controller wishbone map
// ****************************************************************
`define DEAC_WB_CMD 8'h00
`define DEAC_WB_STATUS 8'h04
`define DEAC_WB_WARM 8'h08
`define DEAC_CMD_OP_LSB 16
`define DEAC_CMD_ADDR_LSB 8
`define DEAC_ST_BUSY 0
`define DEAC_ST_VERR 1
`define DEAC_ST_RSP_LSB 8
`endif

// File: rtl/deac_pkg.sv
package deac_pkg;
    typedef enum logic [1:0] {DEAC_ULK_IDLE, DEAC_ULK_KEY1, DEAC_ULK_KEY2} deac_unlock_t;
    typedef enum logic [1:0] {DEAC_OP_READ, DEAC_OP_WRITE, DEAC_OP_CTRL_RD, DEAC_OP_CTRL_CLR} deac_op_t;
    typedef enum logic [4:0] {
        H_IDLE, H_IDX, H_DAT, H_PERM, H_KEY1, H_GAP1, H_KEY2, H_GAP2, H_GO,
        H_POLL, H_POLL_W, H_POLL_CAP, H_CLR, H_DPERM, H_TRIG, H_RD, H_RD_W, H_RD_CAP,
        H_CTRL_RD, H_CTRL_CLR
    } deac_host_state_t;
endpackage

// File: rtl/deac_if.sv
`timescale 1ns/1ps
interface deac_if;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic sfr_we;
    logic sfr_re;
    logic [7:0] sfr_rdata;
    logic warm_rst;
    modport cpu (
        output sfr_addr,
        output sfr_wdata,
        output sfr_we,
        output sfr_re,
        output warm_rst,
        input sfr_rdata
    );
    modport dev (
        input sfr_addr,
        input sfr_wdata,
        input sfr_we,
        input sfr_re,
        input warm_rst,
        output sfr_rdata
    );
endinterface

// File: rtl/deac_host.sv
`timescale 1ns/1ps
`include "deac_defines.svh"
module deac_host (
    input wire logic sys_clk,
    input wire logic nrst,
    deac_if.cpu bus,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    import deac_pkg::*;

    deac_host_state_t st_r;
    logic [17:0] cmd_r;
    logic [7:0] rsp_r;
    logic verr_r;
    logic verify_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic [7:0] addr_r;
    logic [7:0] wdata_r;
    logic we_r;
    logic re_r;
    logic warm_r;
    logic take;
    logic [17:0] cmd_nxt;
    logic start;
    logic warm_req;
    deac_op_t op;

    function automatic logic [17:0] lane_merge(input logic [17:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] m;
        m = {14'h0000, old};
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                m[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return m[17:0];
    endfunction

    // ****************************************************************
    // wishbone slave
    // ****************************************************************
    assign take = wb_cyc_i && wb_stb_i && !ack_r;
    assign cmd_nxt = lane_merge(cmd_r, wb_dat_i, wb_sel_i);
    assign start = take && wb_we_i && wb_adr_i == `DEAC_WB_CMD && st_r == H_IDLE;
    assign warm_req = take && wb_we_i && wb_adr_i == `DEAC_WB_WARM && wb_sel_i[0] && wb_dat_i[0];
    assign op = deac_op_t'(cmd_r[`DEAC_CMD_OP_LSB +: 2]);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= take;
            if (take && !wb_we_i) begin
                case (wb_adr_i)
                    `DEAC_WB_CMD: dat_r <= {14'h0000, cmd_r};
                    `DEAC_WB_STATUS: dat_r <= {16'h0000, rsp_r, 6'h00, verr_r, st_r != H_IDLE};
                    default: dat_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cmd_r <= 18'h0_0000;
        end else if (start) begin
            cmd_r <= cmd_nxt;
        end
    end

    // ****************************************************************
    // special function register sequencer
    // ****************************************************************
    // one state per instruction keeps the unlock spacing exact and uninterruptible
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= H_IDLE;
            addr_r <= 8'h00;
            wdata_r <= 8'h00;
            we_r <= 1'b0;
            re_r <= 1'b0;
            warm_r <= 1'b0;
            rsp_r <= 8'h00;
            verr_r <= 1'b0;
            verify_r <= 1'b0;
        end else begin
            we_r <= 1'b0;
            re_r <= 1'b0;
            warm_r <= warm_req;
            if (warm_req) begin
                st_r <= H_IDLE;
            end else begin
                case (st_r)
                    H_IDLE: begin
                        if (start) begin
                            verify_r <= 1'b0;
                            case (deac_op_t'(cmd_nxt[`DEAC_CMD_OP_LSB +: 2]))
                                DEAC_OP_CTRL_RD: st_r <= H_CTRL_RD;
                                DEAC_OP_CTRL_CLR: st_r <= H_CTRL_CLR;
                                default: st_r <= H_IDX;
                            endcase
                        end
                    end
                    H_IDX: begin
                        {we_r, addr_r, wdata_r} <= {1'b1, `DEAC_INDEX_ADDR, 1'b0, cmd_r[`DEAC_CMD_ADDR_LSB +: 7]};
                        st_r <= (op == DEAC_OP_WRITE && !verify_r) ? H_DAT : H_TRIG;
                    end
                    H_DAT: begin
                        {we_r, addr_r, wdata_r} <= {1'b1, `DEAC_DATA_ADDR, cmd_r[7:0]};
                        st_r <= H_PERM;
                    end
                    H_PERM: begin
                        {we_r, addr_r, wdata_r} <= {1'b1, `DEAC_CTRL_ADDR, `DEAC_CTRL_PERMIT};
                        st_r <= H_KEY1;
                    end
                    H_KEY1: begin
                        {we_r, addr_r, wdata_r} <= {1'b1, `DEAC_KEY_ADDR, `DEAC_KEY_FIRST};
                        st_r <= H_GAP1;
                    end
                    H_GAP1: st_r <= H_KEY2;
                    H_KEY2: begin
                        {we_r, addr_r, wdata_r} <= {1'b1, `DEAC_KEY_ADDR, `DEAC_KEY_SECOND};
                        st_r <= H_GAP2;
                    end
                    H_GAP2: st_r <= H_GO;
                    H_GO: begin
                        {we_r, addr_r, wdata_r} <= {1'b1, `DEAC_CTRL_ADDR, `DEAC_CTRL_GO};
                        st_r <= H_POLL;
                    end
                    // flag and launch polls alternate: a refused launch never sets the flag
                    H_POLL: begin
                        {re_r, addr_r} <= {1'b1, (addr_r == `DEAC_PIR_ADDR) ? `DEAC_CTRL_ADDR : `DEAC_PIR_ADDR};
                        st_r <= H_POLL_W;
                    end
                    H_POLL_W: st_r <= H_POLL_CAP;
                    H_POLL_CAP: begin
                        if (addr_r == `DEAC_PIR_ADDR) begin
                            st_r <= bus.sfr_rdata[`DEAC_DONE_BIT] ? H_CLR : H_POLL;
                        end else begin
                            st_r <= bus.sfr_rdata[`DEAC_LAUNCH_BIT] ? H_POLL : H_CLR;
                        end
                    end
                    H_CLR: begin
                        {we_r, addr_r, wdata_r} <= {1'b1, `DEAC_PIR_ADDR, 8'h00};
                        st_r <= H_DPERM;
                    end
                    H_DPERM: begin
                        {we_r, addr_r, wdata_r} <= {1'b1, `DEAC_CTRL_ADDR, 8'h00};
                        verify_r <= 1'b1;
                        st_r <= H_IDX;
                    end
                    H_TRIG: begin
                        {we_r, addr_r, wdata_r} <= {1'b1, `DEAC_CTRL_ADDR, `DEAC_CTRL_READ};
                        st_r <= H_RD;
                    end
                    H_RD: begin
                        {re_r, addr_r} <= {1'b1, `DEAC_DATA_ADDR};
                        st_r <= H_RD_W;
                    end
                    H_CTRL_RD: begin
                        {re_r, addr_r} <= {1'b1, `DEAC_CTRL_ADDR};
                        st_r <= H_RD_W;
                    end
                    H_RD_W: st_r <= H_RD_CAP;
                    H_RD_CAP: begin
                        rsp_r <= bus.sfr_rdata;
                        if (verify_r) begin
                            verr_r <= bus.sfr_rdata != cmd_r[7:0];
                        end
                        st_r <= H_IDLE;
                    end
                    H_CTRL_CLR: begin
                        {we_r, addr_r, wdata_r} <= {1'b1, `DEAC_CTRL_ADDR, 8'h00};
                        st_r <= H_IDLE;
                    end
                    default: st_r <= H_IDLE;
                endcase
            end
        end
    end

    assign bus.sfr_addr = addr_r;
    assign bus.sfr_wdata = wdata_r;
    assign bus.sfr_we = we_r;
    assign bus.sfr_re = re_r;
    assign bus.warm_rst = warm_r;
    assign wb_dat_o = dat_r;
    assign wb_ack_o = ack_r;
endmodule

// File: testbench/deac_sva.sv
`timescale 1ns/1ps
`include "deac_defines.svh"
module deac_sva #(
    parameter int unsigned SETTLE_CYCLES = 20,
    parameter int unsigned PROG_CYCLES = 8
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_we,
    input wire logic sfr_re,
    input wire logic [7:0] sfr_rdata,
    input wire logic warm_rst
);
    logic perm_r, seen_r;
    logic [31:0] up_r;
    logic [15:0] go_r;
    wire rd_c = sfr_re && sfr_addr == `DEAC_CTRL_ADDR;
    wire wr_c = sfr_we && sfr_addr == `DEAC_CTRL_ADDR;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // counters saturate so long idle spells never wrap
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            perm_r <= 1'b0;
            seen_r <= 1'b0;
            up_r <= 32'h0000_0000;
            go_r <= 16'hffff;
        end else begin
            perm_r <= wr_c ? sfr_wdata[2] : perm_r;
            seen_r <= seen_r | (wr_c & sfr_wdata[2]);
            up_r <= (up_r < SETTLE_CYCLES) ? up_r + 32'h0000_0001 : up_r;
            go_r <= (wr_c && sfr_wdata[1]) ? 16'h0000 : go_r + {15'h0000, go_r != 16'hffff};
        end
    end
    // ********
    // properties, launch bounds carry slack
    // ********
    perm_track_a: assert property (rd_c |=> sfr_rdata[2] == $past(perm_r))
        else $error("permit changed");
    perm_gate_a: assert property (rd_c && !seen_r |=> !sfr_rdata[1])
        else $error("launch without permit");
    rd_clear_a: assert property (rd_c && !$past(sfr_we) |=> !sfr_rdata[0])
        else $error("read bit stuck");
    settle_gate_a: assert property (rd_c && up_r + 2 < SETTLE_CYCLES |=> !sfr_rdata[1])
        else $error("early launch");
    prog_bound_a: assert property (rd_c && go_r > PROG_CYCLES + 3 |=> !sfr_rdata[1])
        else $error("launch too long");
    rdata_hold_a: assert property (!sfr_re |=> $stable(sfr_rdata))
        else $error("read data moved");
    key_value_a: assert property (sfr_we && sfr_addr == `DEAC_KEY_ADDR |->
        sfr_wdata == `DEAC_KEY_FIRST || sfr_wdata == `DEAC_KEY_SECOND)
        else $error("bad unlock key");
    idx_msb_a: assert property (sfr_we && sfr_addr == `DEAC_INDEX_ADDR |-> !sfr_wdata[7])
        else $error("index msb set");
endmodule

// File: testbench/data_eeprom_access_ctrl_tb_top.sv
`timescale 1ns/1ps
module data_eeprom_access_ctrl_tb_top;
    localparam int unsigned SETTLE = 20;
    localparam int unsigned PROG = 40;
    logic sys_clk = 1'b0, nrst = 1'b0, cyc = 1'b0, we = 1'b0, lock = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000;
    logic [6:0] ext_addr = 7'h00;
    logic [31:0] wb_dat_o;
    logic [7:0] ext_data;
    logic wb_ack_o, prog_busy;
    int n_mismatch = 0, tests_run = 0, cycles = 0;
    deac_if bus();
    deac_device #(.SETTLE_CYCLES(SETTLE), .PROG_CYCLES(PROG)) i_deac_device (.sys_clk(sys_clk), .nrst(nrst),
        .bus(bus), .data_readout_lock(lock), .ext_addr(ext_addr), .ext_data(ext_data), .prog_busy(prog_busy));
    deac_host i_deac_host (.sys_clk(sys_clk), .nrst(nrst), .bus(bus), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    deac_sva #(.SETTLE_CYCLES(SETTLE), .PROG_CYCLES(PROG)) i_deac_sva (.sys_clk(sys_clk), .nrst(nrst),
        .sfr_addr(bus.sfr_addr), .sfr_wdata(bus.sfr_wdata), .sfr_we(bus.sfr_we), .sfr_re(bus.sfr_re),
        .sfr_rdata(bus.sfr_rdata), .warm_rst(bus.warm_rst));
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    // ********
    // bus cycles, comparison, verdict
    // ********
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        cyc <= 1'b0;
    endtask
    // status is polled until idle, then the last poll is judged
    task automatic op_chk(input logic [1:0] op, input logic [6:0] ix, input logic [7:0] d,
        input logic [15:0] m, input logic [15:0] e);
        logic [31:0] q;
        wb(1'b1, 8'h00, {14'h0000, op, 1'b0, ix, d}, q);
        do wb(1'b0, 8'h04, 32'h0000_0000, q); while (q[0] !== 1'b0);
        chk(q[15:0] & m, e);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic t_rw();
        op_chk(2'd1, 7'h00, 8'h3c, 16'h0002, 16'h0000);
        op_chk(2'd0, 7'h00, 8'h00, 16'hff00, 16'h3c00);
        op_chk(2'd1, 7'h7f, 8'ha5, 16'h0002, 16'h0000);
        op_chk(2'd1, 7'h7f, 8'h5a, 16'h0002, 16'h0000);
        op_chk(2'd0, 7'h7f, 8'h00, 16'hff00, 16'h5a00);
    endtask
    task automatic t_lock();
        ext_addr <= 7'h7f;
        repeat (8) @(posedge sys_clk);
        chk({8'h00, ext_data}, 16'h005a);
        lock <= 1'b0;
        repeat (8) @(posedge sys_clk);
        chk({8'h00, ext_data}, 16'h0000);
        op_chk(2'd1, 7'h10, 8'h96, 16'h0002, 16'h0000);
        lock <= 1'b1;
    endtask
    // warm reset lands while the write is still self-timing
    task automatic t_abort();
        logic [31:0] q;
        wb(1'b1, 8'h00, 32'h0001_2200, q);
        do @(posedge sys_clk); while (prog_busy !== 1'b1);
        wb(1'b1, 8'h08, 32'h0000_0001, q);
        op_chk(2'd2, 7'h00, 8'h00, 16'h0c00, 16'h0c00);
        op_chk(2'd3, 7'h00, 8'h00, 16'h0c00, 16'h0c00);
        op_chk(2'd2, 7'h00, 8'h00, 16'h0f00, 16'h0000);
        op_chk(2'd0, 7'h22, 8'h00, 16'hff00, 16'hff00);
    endtask
    task automatic t_settle();
        op_chk(2'd1, 7'h33, 8'h11, 16'h0002, 16'h0000);
        nrst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        op_chk(2'd1, 7'h33, 8'hee, 16'h0002, 16'h0002);
        op_chk(2'd0, 7'h33, 8'h00, 16'hff00, 16'h1100);
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (SETTLE) @(posedge sys_clk);
        t_rw();
        t_lock();
        t_abort();
        t_settle();
        tally_and_finish();
    end
endmodule
